// ===== peil_pkg.sv
// How it works
// RL1 - global, module and source enables all gate; the charger flag has no source enable and is always enabled
// RL2 - flags set even when source disabled; pin flags are not set while their config enable bit is clear
// RL3 - firmware clears serviced flags in handler
// RL4 - firmware waits before returning from handler
// RL5 - single shared software-writable handler vector
// RL6 - handler vector resets to zero
// RL7 - source id names system or peripheral module
// RL8 - peripheral flag register gathers all events
// RL9 - pin interrupts gated by alternate function
// RL10 - connect flag when both lines high
// RL11 - disconnect flag after lag, adc on
// RL12 - partial flag when one line rises
// RL13 - charger flag on detect rising edge
// RL14 - brownout flag on exit, no wake
// RL15 - battery flag on protection entry
// RL16 - voltage flag on fresh average, adc on
// RL17 - current flag and charge update together
// RL18 - temperature flag on fresh average, adc on
// RL19 - timer flag on timer rollover pulse
// RL20 - handler reads flags, applies own priority
// RL21 - enable, type and polarity select trigger
// RL22 - request follows enabled pending flags
package peil_pkg;
    localparam int DW = 16;
    localparam int AW = 4;
    localparam int NFLAGS = 12;
    localparam int NPROT = 4;
    localparam int DISC_CW = 27;
    // register offsets
    localparam logic [AW-1:0] ADDR_VECTOR = 4'h0;
    localparam logic [AW-1:0] ADDR_SRC_ID = 4'h1;
    localparam logic [AW-1:0] ADDR_FLAGS = 4'h2;
    localparam logic [AW-1:0] ADDR_CONFIG = 4'h3;
    localparam logic [AW-1:0] ADDR_MASK = 4'h4;
    localparam logic [AW-1:0] ADDR_ALT = 4'h5;
    localparam logic [AW-1:0] ADDR_CTRL = 4'h6;
    localparam logic [AW-1:0] ADDR_PROT = 4'h7;
    // flag positions
    localparam int F_PIN0 = 0;
    localparam int F_PIN1 = 1;
    localparam int F_SCONN = 2;
    localparam int F_SDISC = 3;
    localparam int F_SPART = 4;
    localparam int F_CHG = 5;
    localparam int F_BO = 6;
    localparam int F_BATT = 7;
    localparam int F_VOLT = 8;
    localparam int F_CURR = 9;
    localparam int F_TEMP = 10;
    localparam int F_TIMER = 11;
    // config bits
    localparam int CFG_EN0 = 0;
    localparam int CFG_EN1 = 1;
    localparam int CFG_EDGE0 = 2;
    localparam int CFG_EDGE1 = 3;
    localparam int CFG_POL0 = 4;
    localparam int CFG_POL1 = 5;
    // control and source id bits
    localparam int CTRL_GLOBAL = 0;
    localparam int CTRL_SYS = 1;
    localparam int CTRL_PERIPH = 2;
    localparam int SRC_SYS = 0;
    localparam int SRC_PERIPH = 1;
    // reset values and writable fields
    localparam logic [DW-1:0] VECTOR_RST = 16'h0000;
    localparam logic [5:0] CONFIG_RST = 6'h00;
    localparam logic [NFLAGS-1:0] MASK_RST = 12'h000;
    localparam logic [NFLAGS-1:0] MASK_WR = 12'hFDC;
    localparam logic [NFLAGS-1:0] BO_ONLY = 12'h040;
    localparam logic [1:0] ALT_RST = 2'h0;
    localparam logic [2:0] CTRL_RST = 3'h0;
    // timing
    localparam int CLK_MHZ = 200;
    localparam int DISC_LAG_MS = 440;
    localparam int DISC_LAG_CYC = DISC_LAG_MS * CLK_MHZ * 1000;
endpackage

module peil_pin_detect
    import peil_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // pin and its controls
    input wire logic pin_async,
    input wire logic enable,
    input wire logic edge_mode,
    input wire logic polarity,
    // detection
    output logic hit
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
    } peil_pin_t;

    peil_pin_t st_q;
    peil_pin_t st_d;
    logic active;
    logic prev_active;

    always_comb
    begin
        st_d.s1 = pin_async;
        st_d.s2 = st_q.s1;
        st_d.prev = st_q.s2;
        if (reset)
        begin
            st_d = '0;
        end
        active = polarity ? st_q.s2 : ~st_q.s2; // [RL21]
        prev_active = polarity ? st_q.prev : ~st_q.prev;
        hit = enable & (edge_mode ? (active & ~prev_active) : active); // [RL21]
    end

    always_ff @(posedge core_clk)
    begin
        st_q <= st_d;
    end
endmodule // peil_pin_detect

// ===== peil_event_irq.sv
// Design decisions made here: the register addresses and strobed register access.
module peil_event_irq
    import peil_pkg::*;
#(
    parameter int DISC_LAG_CYCLES = DISC_LAG_CYC
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // register port
    input wire logic [AW-1:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DW-1:0] reg_rdata,
    // pins and comparators
    input wire logic pin0_irq,
    input wire logic pin1_irq,
    input wire logic serial_clk_pin,
    input wire logic serial_data_pin,
    input wire logic charger_detect,
    input wire logic brownout_active,
    // on-chip event sources
    input wire logic adc_on,
    input wire logic [NPROT-1:0] prot_cond,
    input wire logic voltage_stored,
    input wire logic current_stored,
    input wire logic temp_stored,
    input wire logic timer_rollover,
    input wire logic sys_irq_pending,
    // core side
    output logic irq_req,
    output logic irq_wake,
    output logic [DW-1:0] handler_vector,
    output logic accumulated_charge_update
);
    typedef struct packed {
        logic [1:0] ser_s1;
        logic [1:0] ser_s2;
        logic [1:0] ser_prev;
        logic chg_s1;
        logic chg_s2;
        logic chg_prev;
        logic bo_s1;
        logic bo_s2;
        logic bo_prev;
        logic prot_prev;
        logic [DISC_CW-1:0] disc_cnt;
        logic disc_done;
        logic [NFLAGS-1:0] flags;
        logic [DW-1:0] vector;
        logic [5:0] irq_cfg;
        logic [NFLAGS-1:0] mask;
        logic [1:0] alt;
        logic [2:0] ctrl;
        logic [NPROT-1:0] prot;
        logic [DW-1:0] rdata;
        logic irq;
        logic wake;
        logic charge_upd;
    } peil_state_t;

    localparam logic [DISC_CW-1:0] DISC_LAST = DISC_CW'(DISC_LAG_CYCLES - 1);

    peil_state_t st_q;
    peil_state_t st_d;
    logic hit0;
    logic hit1;
    logic [NFLAGS-1:0] set;
    logic [NFLAGS-1:0] clr;
    logic [NFLAGS-1:0] eff;
    logic [1:0] src;
    logic periph_pend;
    logic periph_wake;
    logic both_high;
    logic both_low;

    // pin detectors, flag set regardless of alternate function
    peil_pin_detect u_pin0 (
        .core_clk(core_clk),
        .reset(reset),
        .pin_async(pin0_irq),
        .enable(st_q.irq_cfg[CFG_EN0]),
        .edge_mode(st_q.irq_cfg[CFG_EDGE0]),
        .polarity(st_q.irq_cfg[CFG_POL0]),
        .hit(hit0)
    );

    peil_pin_detect u_pin1 (
        .core_clk(core_clk),
        .reset(reset),
        .pin_async(pin1_irq),
        .enable(st_q.irq_cfg[CFG_EN1]),
        .edge_mode(st_q.irq_cfg[CFG_EDGE1]),
        .polarity(st_q.irq_cfg[CFG_POL1]),
        .hit(hit1)
    );

    always_comb
    begin
        st_d = st_q;
        // synchronisers
        st_d.ser_s1 = {serial_data_pin, serial_clk_pin};
        st_d.ser_s2 = st_q.ser_s1;
        st_d.ser_prev = st_q.ser_s2;
        st_d.chg_s1 = charger_detect;
        st_d.chg_s2 = st_q.chg_s1;
        st_d.chg_prev = st_q.chg_s2;
        st_d.bo_s1 = brownout_active;
        st_d.bo_s2 = st_q.bo_s1;
        st_d.bo_prev = st_q.bo_s2;
        st_d.prot_prev = |prot_cond;
        st_d.prot = prot_cond; // [RL15]
        both_high = &st_q.ser_s2;
        both_low = ~|st_q.ser_s2;
        // event detection
        set = '0;
        set[F_PIN0] = hit0; // [RL9]
        set[F_PIN1] = hit1; // [RL9]
        set[F_SCONN] = both_high & ~(&st_q.ser_prev); // [RL10]
        set[F_SPART] = (~|st_q.ser_prev) & (^st_q.ser_s2); // [RL12]
        set[F_CHG] = st_q.chg_s2 & ~st_q.chg_prev; // [RL13]
        set[F_BO] = ~st_q.bo_s2 & st_q.bo_prev; // [RL14]
        set[F_BATT] = (|prot_cond) & ~st_q.prot_prev; // [RL15]
        set[F_VOLT] = voltage_stored & adc_on; // [RL16]
        set[F_CURR] = current_stored; // [RL17]
        set[F_TEMP] = temp_stored & adc_on; // [RL18]
        set[F_TIMER] = timer_rollover; // [RL19]
        // disconnect lag timer
        if (!both_low || !adc_on)
        begin
            st_d.disc_cnt = '0; // [RL11]
            st_d.disc_done = 1'b0;
        end
        else if (!st_q.disc_done)
        begin
            if (st_q.disc_cnt == DISC_LAST)
            begin
                set[F_SDISC] = 1'b1; // [RL11]
                st_d.disc_done = 1'b1;
            end
            else
            begin
                st_d.disc_cnt = st_q.disc_cnt + 1'b1;
            end
        end
        // write one to clear, set wins
        clr = '0;
        if (reg_wr && reg_addr == ADDR_FLAGS)
        begin
            clr = reg_wdata[NFLAGS-1:0];
        end
        st_d.flags = (st_q.flags & ~clr) | set; // [RL2] [RL8]
        // register writes
        if (reg_wr)
        begin
            if (reg_addr == ADDR_VECTOR)
            begin
                st_d.vector = reg_wdata; // [RL5]
            end
            else if (reg_addr == ADDR_CONFIG)
            begin
                st_d.irq_cfg = reg_wdata[5:0];
            end
            else if (reg_addr == ADDR_MASK)
            begin
                st_d.mask = reg_wdata[NFLAGS-1:0] & MASK_WR;
            end
            else if (reg_addr == ADDR_ALT)
            begin
                st_d.alt = reg_wdata[1:0];
            end
            else if (reg_addr == ADDR_CTRL)
            begin
                st_d.ctrl = reg_wdata[2:0];
            end
        end
        // effective per-source enables
        eff = st_q.mask;
        eff[F_PIN0] = st_q.alt[0] & st_q.irq_cfg[CFG_EN0]; // [RL9]
        eff[F_PIN1] = st_q.alt[1] & st_q.irq_cfg[CFG_EN1]; // [RL9]
        eff[F_CHG] = 1'b1;
        periph_pend = st_q.ctrl[CTRL_PERIPH] & (|(st_q.flags & eff));
        periph_wake = st_q.ctrl[CTRL_PERIPH] & (|(st_q.flags & eff & ~BO_ONLY)); // [RL14]
        src = '0;
        src[SRC_SYS] = st_q.ctrl[CTRL_SYS] & sys_irq_pending; // [RL7]
        src[SRC_PERIPH] = periph_pend; // [RL7]
        st_d.irq = st_q.ctrl[CTRL_GLOBAL] & (|src); // [RL1] [RL22]
        st_d.wake = st_q.ctrl[CTRL_GLOBAL] & (src[SRC_SYS] | periph_wake); // [RL14]
        st_d.charge_upd = current_stored; // [RL17]
        // read data, valid the cycle after the strobe
        st_d.rdata = '0;
        if (reg_rd)
        begin
            if (reg_addr == ADDR_VECTOR)
            begin
                st_d.rdata = st_q.vector;
            end
            else if (reg_addr == ADDR_SRC_ID)
            begin
                st_d.rdata = {14'h0000, src}; // [RL7]
            end
            else if (reg_addr == ADDR_FLAGS)
            begin
                st_d.rdata = {4'h0, st_q.flags};
            end
            else if (reg_addr == ADDR_CONFIG)
            begin
                st_d.rdata = {10'h000, st_q.irq_cfg};
            end
            else if (reg_addr == ADDR_MASK)
            begin
                st_d.rdata = {4'h0, st_q.mask};
            end
            else if (reg_addr == ADDR_ALT)
            begin
                st_d.rdata = {14'h0000, st_q.alt};
            end
            else if (reg_addr == ADDR_CTRL)
            begin
                st_d.rdata = {13'h0000, st_q.ctrl};
            end
            else if (reg_addr == ADDR_PROT)
            begin
                st_d.rdata = {12'h000, st_q.prot}; // [RL15]
            end
        end
        if (reset)
        begin
            st_d = '0;
            // history keeps sampling so no false edge follows reset
            st_d.ser_s1 = {serial_data_pin, serial_clk_pin};
            st_d.ser_s2 = st_q.ser_s1;
            st_d.ser_prev = st_q.ser_s2;
            st_d.chg_s1 = charger_detect;
            st_d.chg_s2 = st_q.chg_s1;
            st_d.chg_prev = st_q.chg_s2;
            st_d.bo_s1 = brownout_active;
            st_d.bo_s2 = st_q.bo_s1;
            st_d.bo_prev = st_q.bo_s2;
            st_d.prot_prev = |prot_cond;
            st_d.vector = VECTOR_RST; // [RL6]
            st_d.irq_cfg = CONFIG_RST;
            st_d.mask = MASK_RST;
            st_d.alt = ALT_RST;
            st_d.ctrl = CTRL_RST;
        end
    end

    always_ff @(posedge core_clk)
    begin
        st_q <= st_d;
    end

    assign reg_rdata = st_q.rdata;
    assign irq_req = st_q.irq;
    assign irq_wake = st_q.wake;
    assign handler_vector = st_q.vector;
    assign accumulated_charge_update = st_q.charge_upd;

    // checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    sequence lines_low_s;
        st_q.ser_s2 == 2'b00;
    endsequence

    sequence one_line_up_s;
        ^st_q.ser_s2;
    endsequence

    sequence lines_up_s;
        st_q.ser_s2 == 2'b11;
    endsequence

    irq_gate_a: assert property (irq_req |-> $past(st_q.ctrl[CTRL_GLOBAL]) && $past(|src)) // [RL1]
        else $error("request without enables");
    masked_set_a: assert property (timer_rollover && !st_q.mask[F_TIMER] |=> st_q.flags[F_TIMER]) // [RL2]
        else $error("masked event lost");
    set_wins_a: assert property (reg_wr && reg_addr == ADDR_FLAGS && reg_wdata[F_CURR] && current_stored // [RL17]
        |=> st_q.flags[F_CURR] ##0 accumulated_charge_update)
        else $error("set lost against clear");
    vector_wr_a: assert property (reg_wr && reg_addr == ADDR_VECTOR |=> handler_vector == $past(reg_wdata)) // [RL5]
        else $error("vector not written");
    vector_rst_a: assert property (@(posedge core_clk) disable iff (1'b0) // [RL6]
        reset |=> handler_vector == VECTOR_RST)
        else $error("vector reset wrong");
    src_read_a: assert property (reg_rd && reg_addr == ADDR_SRC_ID |=> reg_rdata == {14'h0000, $past(src)}) // [RL7]
        else $error("source id read wrong");
    connect_a: assert property (lines_low_s ##1 lines_up_s |=> st_q.flags[F_SCONN]) // [RL10]
        else $error("connect flag missed");
    disc_adc_a: assert property ($rose(st_q.flags[F_SDISC]) |-> $past(adc_on) && $past(both_low)) // [RL11]
        else $error("disconnect flag wrong");
    partial_a: assert property (lines_low_s ##1 one_line_up_s |=> st_q.flags[F_SPART]) // [RL12]
        else $error("partial flag missed");
    charger_a: assert property ($rose(st_q.chg_s2) |=> st_q.flags[F_CHG]) // [RL13]
        else $error("charger flag missed");
    brownout_a: assert property ($fell(st_q.bo_s2) |=> st_q.flags[F_BO]) // [RL14]
        else $error("brownout flag missed");
    bo_wake_a: assert property (st_q.ctrl[CTRL_GLOBAL] && st_q.ctrl[CTRL_PERIPH] && !src[SRC_SYS] // [RL14]
        && (st_q.flags & eff) == BO_ONLY |=> irq_req && !irq_wake)
        else $error("brownout flag woke core");
    battery_a: assert property ($rose(|prot_cond) |=> st_q.flags[F_BATT]) // [RL15]
        else $error("battery flag missed");
    volt_off_a: assert property (!st_q.flags[F_VOLT] && !adc_on |=> !st_q.flags[F_VOLT]) // [RL16]
        else $error("voltage flag with adc off");
    temp_off_a: assert property (!st_q.flags[F_TEMP] && !adc_on |=> !st_q.flags[F_TEMP]) // [RL18]
        else $error("temperature flag with adc off");
    pin_hit_a: assert property (hit0 |=> st_q.flags[F_PIN0]) // [RL21]
        else $error("pin flag missed");
    irq_drop_a: assert property (!(|src) |=> !irq_req) // [RL22]
        else $error("request without pending flag");
endmodule // peil_event_irq

// ===== peil_core_model.sv
module peil_core_model
    import peil_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // request and read data
    input wire logic enable,
    input wire logic irq_req,
    input wire logic [DW-1:0] reg_rdata,
    // register port out
    output logic [AW-1:0] m_addr,
    output logic [DW-1:0] m_wdata,
    output logic m_wr,
    output logic m_rd,
    output int served
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DW-1:0] src;
    logic [DW-1:0] fl;
    initial
    begin
        m_addr = '0;
        m_wdata = '0;
        m_wr = 1'b0;
        m_rd = 1'b0;
        served = 0;
    end
    // one handler pass per request
    always
    begin
        @(negedge core_clk);
        if (enable && !reset && irq_req === 1'b1)
        begin
            @(posedge core_clk);
            m_rd <= 1'b1;
            m_addr <= ADDR_SRC_ID;
            @(posedge core_clk);
            m_addr <= ADDR_FLAGS;
            @(negedge core_clk);
            src = reg_rdata;
            @(posedge core_clk);
            m_rd <= 1'b0;
            @(negedge core_clk);
            fl = reg_rdata;
            @(posedge core_clk);
            m_wr <= src[SRC_PERIPH];
            m_wdata <= fl;
            @(posedge core_clk);
            m_wr <= 1'b0;
            repeat (2) @(posedge core_clk);
            served <= served + 1;
        end
    end
endmodule // peil_core_model

// ===== test_pack_event_interrupt_logic.sv
module test_pack_event_interrupt_logic
    import peil_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [AW-1:0] b_addr = '0;
    logic [DW-1:0] b_wdata = '0;
    logic b_wr = 1'b0;
    logic b_rd = 1'b0;
    logic [AW-1:0] m_addr;
    logic [DW-1:0] m_wdata;
    logic m_wr;
    logic m_rd;
    logic model_en = 1'b0;
    int served;
    logic [DW-1:0] reg_rdata;
    logic pin0 = 1'b0;
    logic pin1 = 1'b0;
    logic sclk = 1'b0;
    logic sdat = 1'b0;
    logic chg = 1'b0;
    logic bo = 1'b0;
    logic adc_on = 1'b0;
    logic [NPROT-1:0] prot = '0;
    logic [3:0] pls = '0;
    logic sys_pend = 1'b0;
    logic irq_req;
    logic irq_wake;
    logic [DW-1:0] hvec;
    logic charge_upd;
    int err_count = 0;
    int num_checks = 0;
    int i;
    initial
    begin
        forever #2.5 core_clk = ~core_clk;
    end
    peil_event_irq #(.DISC_LAG_CYCLES(8)) dut (.core_clk(core_clk), .reset(reset),
        .reg_addr(model_en ? m_addr : b_addr), .reg_wdata(model_en ? m_wdata : b_wdata),
        .reg_wr(model_en ? m_wr : b_wr), .reg_rd(model_en ? m_rd : b_rd), .reg_rdata(reg_rdata),
        .pin0_irq(pin0), .pin1_irq(pin1), .serial_clk_pin(sclk), .serial_data_pin(sdat),
        .charger_detect(chg), .brownout_active(bo), .adc_on(adc_on), .prot_cond(prot),
        .voltage_stored(pls[0]), .current_stored(pls[1]), .temp_stored(pls[2]),
        .timer_rollover(pls[3]), .sys_irq_pending(sys_pend), .irq_req(irq_req),
        .irq_wake(irq_wake), .handler_vector(hvec), .accumulated_charge_update(charge_upd));
    peil_core_model core (.core_clk(core_clk), .reset(reset), .enable(model_en), .irq_req(irq_req),
        .reg_rdata(reg_rdata), .m_addr(m_addr), .m_wdata(m_wdata), .m_wr(m_wr), .m_rd(m_rd),
        .served(served));
    function automatic logic [DW-1:0] b(input int k);
        return 16'h0001 << k;
    endfunction
    task automatic chk(input string nm, input logic [DW-1:0] exp, input logic [DW-1:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge core_clk);
        b_wr <= 1'b1;
        b_addr <= a;
        b_wdata <= d;
        @(posedge core_clk);
        b_wr <= 1'b0;
    endtask
    task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] exp);
        @(posedge core_clk);
        b_rd <= 1'b1;
        b_addr <= a;
        @(posedge core_clk);
        b_rd <= 1'b0;
        @(negedge core_clk);
        chk("reg_rdata", exp, reg_rdata);
    endtask
    task automatic fl(input logic [DW-1:0] exp);
        rd(ADDR_FLAGS, exp);
        wr(ADDR_FLAGS, 16'hFFFF);
    endtask
    task automatic pulse(input logic [3:0] p);
        @(posedge core_clk);
        pls <= p;
        @(posedge core_clk);
        pls <= 4'h0;
    endtask
    task automatic irq(input logic r);
        tick(4);
        chk("irq_req", {15'h0, r}, {15'h0, irq_req});
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        wrap_up();
    end
    initial
    begin
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        tick(1);
        chk("handler_vector", 16'h0000, hvec);
        for (i = 0; i < 16; i++) rd(i[AW-1:0], 16'h0000);
        wr(ADDR_VECTOR, 16'hA5C3);
        rd(ADDR_VECTOR, 16'hA5C3);
        chk("handler_vector", 16'hA5C3, hvec);
        pulse(4'h8);
        irq(1'b0);
        rd(ADDR_FLAGS, b(F_TIMER));
        wr(ADDR_MASK, 16'hFFFF);
        rd(ADDR_MASK, {4'h0, MASK_WR});
        wr(ADDR_MASK, b(F_TIMER));
        wr(ADDR_CTRL, 16'h0001);
        irq(1'b0);
        wr(ADDR_CTRL, 16'h0004);
        irq(1'b0);
        wr(ADDR_CTRL, 16'h0005);
        irq(1'b1);
        rd(ADDR_SRC_ID, b(SRC_PERIPH));
        wr(ADDR_FLAGS, b(F_TIMER));
        irq(1'b0);
        @(posedge core_clk);
        sys_pend <= 1'b1;
        wr(ADDR_CTRL, 16'h0003);
        irq(1'b1);
        rd(ADDR_SRC_ID, b(SRC_SYS));
        @(posedge core_clk);
        sys_pend <= 1'b0;
        wr(ADDR_CTRL, 16'h0005);
        sclk <= 1'b1;
        tick(6);
        @(posedge core_clk);
        sdat <= 1'b1;
        tick(6);
        fl(b(F_SPART) | b(F_SCONN));
        sclk <= 1'b0;
        sdat <= 1'b0;
        tick(20);
        fl(16'h0000);
        adc_on <= 1'b1;
        tick(20);
        fl(b(F_SDISC));
        tick(20);
        fl(16'h0000);
        sclk <= 1'b1;
        sdat <= 1'b1;
        tick(6);
        fl(b(F_SCONN));
        adc_on <= 1'b0;
        pulse(4'h5);
        tick(2);
        fl(16'h0000);
        adc_on <= 1'b1;
        pulse(4'h7);
        @(negedge core_clk);
        chk("accumulated_charge_update", 16'h0001, {15'h0, charge_upd});
        tick(2);
        fl(b(F_VOLT) | b(F_CURR) | b(F_TEMP));
        @(posedge core_clk);
        pls <= 4'h2;
        b_wr <= 1'b1;
        b_addr <= ADDR_FLAGS;
        b_wdata <= 16'hFFFF;
        @(posedge core_clk);
        pls <= 4'h0;
        b_wr <= 1'b0;
        fl(b(F_CURR));
        chg <= 1'b1;
        tick(6);
        fl(b(F_CHG));
        tick(6);
        fl(16'h0000);
        wr(ADDR_MASK, {4'h0, BO_ONLY});
        bo <= 1'b1;
        tick(6);
        rd(ADDR_FLAGS, 16'h0000);
        @(posedge core_clk);
        bo <= 1'b0;
        irq(1'b1);
        chk("irq_wake", 16'h0000, {15'h0, irq_wake});
        fl(b(F_BO));
        prot <= 4'h1;
        tick(2);
        @(posedge core_clk);
        prot <= 4'h3;
        tick(2);
        rd(ADDR_PROT, 16'h0003);
        fl(b(F_BATT));
        tick(2);
        fl(16'h0000);
        prot <= 4'h0;
        wr(ADDR_ALT, 16'h0001);
        wr(ADDR_CONFIG, 16'h0015);
        pin0 <= 1'b1;
        irq(1'b1);
        fl(b(F_PIN0));
        tick(4);
        fl(16'h0000);
        wr(ADDR_CONFIG, 16'h0001);
        pin0 <= 1'b0;
        tick(6);
        fl(b(F_PIN0));
        wr(ADDR_CONFIG, 16'h0000);
        wr(ADDR_FLAGS, 16'hFFFF);
        tick(6);
        fl(16'h0000);
        wr(ADDR_ALT, 16'h0000);
        wr(ADDR_CONFIG, 16'h002A);
        pin1 <= 1'b1;
        irq(1'b0);
        fl(b(F_PIN1));
        wr(ADDR_CONFIG, 16'h000A);
        pin1 <= 1'b0;
        tick(6);
        fl(b(F_PIN1));
        wr(ADDR_CONFIG, 16'h0011);
        pin0 <= 1'b1;
        tick(6);
        fl(b(F_PIN0));
        wr(ADDR_CONFIG, 16'h0000);
        wr(ADDR_FLAGS, 16'hFFFF);
        wr(ADDR_MASK, b(F_TIMER));
        tick(2);
        @(posedge core_clk);
        model_en <= 1'b1;
        pulse(4'h8);
        for (i = 0; i < 60 && served == 0; i++) tick(1);
        chk("served", 16'h0001, served[DW-1:0]);
        irq(1'b0);
        @(posedge core_clk);
        model_en <= 1'b0;
        rd(ADDR_FLAGS, 16'h0000);
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        tick(1);
        chk("handler_vector", 16'h0000, hvec);
        tick(4);
        rd(ADDR_FLAGS, 16'h0000);
        wrap_up();
    end
endmodule // test_pack_event_interrupt_logic
